/* File: rtl/dscp_host.sv */
// Host end: APB-controlled frame sender with post-reset hold-offs
module dscp_host (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device reset notice
  input  wire logic        dev_reset_seen,
  // Link
  dscp_link_if.host        link
);
  logic [31:0]             word_reg;
  logic [31:0]             tx_reg;
  logic                    hcrc_reg;
  logic                    short_reg;
  logic [5:0]              left_reg;
  logic [1:0]              div_reg;
  localparam int unsigned WAIT_W_L = 16;
  logic [WAIT_W_L-1:0]     wait_reg;
  logic                    sclk_reg;
  logic                    sync_n_reg;
  logic                    sdin_reg;
  dscp_pkg::dscp_hstate_t  st_reg;

  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire hit_c   = paddr == dscp_pkg::A_CTRL;
  wire hit_w   = paddr == dscp_pkg::A_WORD;
  wire hit_s   = paddr == dscp_pkg::A_STATUS;
  wire busy    = st_reg != dscp_pkg::HS_IDLE;
  wire hold    = wait_reg != '0;
  // RULE14: refresh command starts the long wait
  wire is_cal  = word_reg[28:24] == dscp_pkg::REG_GEN_CFG2
                 && word_reg[23:8] == dscp_pkg::CAL_REFRESH;
  wire go      = wr && hit_c && pwdata[dscp_pkg::GO_BIT] && !busy && !hold;
  // Frame options come from the same control write that starts it
  wire hcrc_new  = pwdata[dscp_pkg::HCRC_BIT];
  wire short_new = pwdata[dscp_pkg::SHORT_BIT];
  wire [31:0] frame = hcrc_new
                 ? {word_reg[31:8], dscp_pkg::dscp_crc24(word_reg[31:8])}
                 : (short_new ? {word_reg[31:8], 8'h00} : word_reg);
  wire tick    = div_reg == 2'(dscp_pkg::HALF_DIV - 1);
  wire [31:0] rdata = hit_c ? {29'h0, short_reg, hcrc_reg, 1'b0}
                 : hit_w ? word_reg
                 : hit_s ? {30'h0, hold, busy} : 32'h0000_0000;

  // APB answers in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !pready;
      pslverr <= psel && !pready && !(hit_c || hit_w || hit_s);
      prdata  <= (psel && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg  <= 32'h0000_0000;
      hcrc_reg  <= 1'b1;
      short_reg <= 1'b0;
    end else if (clk_en && wr && pready) begin
      if (hit_w) begin
        word_reg <= pwdata;
      end
      if (hit_c) begin
        hcrc_reg  <= pwdata[dscp_pkg::HCRC_BIT];
        short_reg <= pwdata[dscp_pkg::SHORT_BIT];
      end
    end
  end

  // RULE17: hold-off after reset, RULE14 after refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= WAIT_W_L'(dscp_pkg::RESET_WAIT_CYC);
    end else if (clk_en) begin
      if (dev_reset_seen) begin
        wait_reg <= WAIT_W_L'(dscp_pkg::RESET_WAIT_CYC);
      end else if (st_reg == dscp_pkg::HS_END && is_cal) begin
        wait_reg <= WAIT_W_L'(dscp_pkg::CAL_WAIT_CYC);
      end else if (hold) begin
        wait_reg <= wait_reg - 1'b1;
      end
    end
  end

  // RULE1: clock divider keeps link at 50 MHz max
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= dscp_pkg::HS_IDLE;
      div_reg    <= 2'h0;
      tx_reg     <= 32'h0000_0000;
      left_reg   <= 6'h00;
      sclk_reg   <= 1'b1;
      sync_n_reg <= 1'b1;
      sdin_reg   <= 1'b0;
    end else if (clk_en) begin
      div_reg <= (busy && !tick) ? div_reg + 2'h1 : 2'h0;
      case (st_reg)
        dscp_pkg::HS_IDLE: begin
          if (go && pready) begin
            // RULE19: select low frames the word
            sync_n_reg <= 1'b0;
            // RULE4: MSB first from bit 31
            tx_reg     <= {frame[30:0], 1'b0};
            sdin_reg   <= frame[31];
            left_reg   <= (short_new && !hcrc_new) ? dscp_pkg::SHORT_CNT : dscp_pkg::FRAME_CNT;
            st_reg     <= dscp_pkg::HS_HIGH;
          end
        end
        dscp_pkg::HS_HIGH: if (tick) begin
          // RULE5: falling edge with data stable
          sclk_reg <= 1'b0;
          left_reg <= left_reg - 6'h01;
          st_reg   <= dscp_pkg::HS_LOW;
        end
        dscp_pkg::HS_LOW: if (tick) begin
          sclk_reg <= 1'b1;
          if (left_reg == 6'h00) begin
            st_reg <= dscp_pkg::HS_END;
          end else begin
            sdin_reg <= tx_reg[31];
            tx_reg   <= {tx_reg[30:0], 1'b0};
            st_reg   <= dscp_pkg::HS_HIGH;
          end
        end
        dscp_pkg::HS_END: begin
          sync_n_reg <= 1'b1;
          st_reg     <= dscp_pkg::HS_IDLE;
        end
        default: st_reg <= dscp_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.sclk   = sclk_reg;
  assign link.sync_n = sync_n_reg;
  assign link.sdin   = sdin_reg;
endmodule

/* File: pkg/dscp_pkg.sv */
// Shared constants and types for the serial control port and its host
package dscp_pkg;
  // Frame geometry
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned SHORT_BITS   = 24;
  localparam int unsigned CNT_W        = 6;
  localparam logic [5:0]  FRAME_CNT    = 6'h20;
  localparam logic [5:0]  SHORT_CNT    = 6'h18;
  localparam int unsigned SLIP_POS     = 31;
  localparam int unsigned DEV_HI       = 30;
  localparam int unsigned DEV_LO       = 29;
  localparam int unsigned REG_HI       = 28;
  localparam int unsigned REG_LO       = 24;
  localparam int unsigned DATA_HI      = 23;
  localparam int unsigned DATA_LO      = 8;
  localparam int unsigned CRC_HI       = 7;
  localparam int unsigned CRC_LO       = 0;
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  // Device register addresses
  localparam logic [4:0]  REG_DATA     = 5'h01;
  localparam logic [4:0]  REG_DAC_CFG  = 5'h06;
  localparam logic [4:0]  REG_SW_RESET = 5'h08;
  localparam logic [4:0]  REG_REG_CFG1 = 5'h09;
  localparam logic [4:0]  REG_REG_CFG2 = 5'h0A;
  localparam logic [4:0]  REG_GEN_CFG1 = 5'h0D;
  localparam logic [4:0]  REG_GEN_CFG2 = 5'h0E;
  localparam logic [15:0] SW_RESET_KEY = 16'h1DAC;
  localparam logic [15:0] CAL_REFRESH  = 16'hFCBA;
  // Field positions
  localparam int unsigned RANGE_HI     = 3;
  localparam int unsigned RANGE_LO     = 0;
  localparam int unsigned OVR_BIT      = 4;
  localparam int unsigned OUT_EN_BIT   = 6;
  localparam int unsigned VMODE_BIT    = 7;
  localparam int unsigned LEVEL_HI     = 4;
  localparam int unsigned LEVEL_LO     = 0;
  localparam int unsigned PPC_BIT      = 5;
  localparam int unsigned PULLDN_BIT   = 0;
  localparam int unsigned CRC_EN_BIT   = 0;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [15:0] GEN2_RESET   = 16'h0001;
  // Host timing at 100 MHz
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned LINK_MHZ_MAX = 50;
  localparam int unsigned HALF_DIV     = (CLK_MHZ + 2 * LINK_MHZ_MAX - 1) / (2 * LINK_MHZ_MAX);
  localparam int unsigned RESET_WAIT_US = 100;
  localparam int unsigned CAL_WAIT_US   = 500;
  localparam int unsigned RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  localparam int unsigned CAL_WAIT_CYC   = CAL_WAIT_US * CLK_MHZ;
  localparam int unsigned WAIT_W        = 16;
  // Host APB map
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_WORD   = 8'h04;
  localparam logic [7:0]  A_STATUS = 8'h08;
  localparam int unsigned GO_BIT     = 0;
  localparam int unsigned HCRC_BIT   = 1;
  localparam int unsigned SHORT_BIT  = 2;
  localparam int unsigned BUSY_BIT   = 0;
  localparam int unsigned HOLD_BIT   = 1;

  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} dscp_hstate_t;

  // CRC-8 over one bit, MSB first
  function automatic logic [7:0] dscp_crc_step(input logic [7:0] c, input logic b);
    dscp_crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  // CRC-8 over the 24 header and data bits
  function automatic logic [7:0] dscp_crc24(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = dscp_crc_step(c, w[i]);
    end
    dscp_crc24 = c;
  endfunction
endpackage

/* File: pkg/dscp_link_if.sv */
// Four-wire serial link between host and device
interface dscp_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic sdo;
  modport host (output sclk, output sync_n, output sdin, input sdo);
  modport device (input sclk, input sync_n, input sdin, output sdo);
endinterface

/* File: rtl/dscp_device.sv */
// Device end: frame receiver, configuration registers and reset handling
// How it works
// RULE1: Accepts serial clock up to 50 MHz
// RULE2: Data codes are always straight binary
// RULE3: Checksum on at reset, 32-bit frame
// RULE4: Frames shift in MSB first, 32 bits
// RULE5: Input data sampled on falling clock edge
// RULE6: Checksum off uses 24-bit frame
// RULE7: Checksum off ignores extra eight bits
// RULE8: Slip, address, register, data, checksum layout
// RULE9: Never both output stages enabled together
// RULE10: Voltage overrange bit in converter configuration
// RULE11: Output channel disabled after any reset
// RULE12: Pull-down open; set by regulator register two
// RULE13: Host refreshes calibration after every reset; dscp_host sends a refresh only when software writes one
// RULE14: Host waits 500 us after refresh
// RULE15: Reset pin or software reset command
// RULE16: Held in reset while supply low
// RULE17: Host silent 100 us after reset
// RULE18: Programmable supply level from bits 4:0
// RULE19: Frame acted on when select rises
module dscp_device (
  // Link, sampled on its own clock
  dscp_link_if.device        link,
  // Resets and supply monitor
  input  wire logic          reset_pin_n,
  input  wire logic          supply_ok,
  input  wire logic          dev_addr_strap_0,
  input  wire logic          dev_addr_strap_1,
  input  wire logic          clk_en,
  // User side
  output logic               in_reset,
  output logic [15:0]        dac_code,
  output logic               current_en,
  output logic               voltage_en,
  output logic               overrange_en,
  output logic [3:0]         out_range,
  output logic               pulldown_closed,
  output logic               ppc_mode,
  output logic [4:0]         supply_level,
  output logic               cal_refresh,
  output logic               crc_error
);
  logic [31:0] shift_reg;
  logic [5:0]  count_reg;
  logic        crc_en_reg;
  logic [15:0] dac_cfg_reg;
  logic [15:0] reg_cfg1_reg;
  logic [15:0] reg_cfg2_reg;
  logic        sw_reset_reg;
  logic        cal_reg;
  logic        crc_err_reg;
  logic        frame_tog_reg;
  logic        seen_tog_reg;

  // RULE16: supply monitor holds reset
  wire rst_n = reset_pin_n & supply_ok & ~sw_reset_reg;

  wire [4:0]  f_reg   = shift_reg[dscp_pkg::REG_HI:dscp_pkg::REG_LO];
  wire [1:0]  f_dev   = shift_reg[dscp_pkg::DEV_HI:dscp_pkg::DEV_LO];
  wire [15:0] f_data  = shift_reg[dscp_pkg::DATA_HI:dscp_pkg::DATA_LO];
  wire [7:0]  f_crc   = shift_reg[dscp_pkg::CRC_HI:dscp_pkg::CRC_LO];
  // RULE6: short frame aligned in low 24 bits
  wire [23:0] s_word  = shift_reg[23:0];
  wire        full_f  = count_reg == dscp_pkg::FRAME_CNT;
  wire        short_f = count_reg == dscp_pkg::SHORT_CNT;
  // RULE8: checksum covers the upper 24 bits
  wire        crc_ok  = dscp_pkg::dscp_crc24(shift_reg[31:8]) == f_crc;
  // RULE7: with checksum off a long frame drops last byte
  wire [23:0] cmd     = (crc_en_reg || full_f) ? shift_reg[31:8] : s_word;
  wire        len_ok  = crc_en_reg ? full_f : (full_f || short_f);
  wire        good    = len_ok && (!crc_en_reg || crc_ok)
                        && (cmd[22:21] == {dev_addr_strap_1, dev_addr_strap_0});
  wire [4:0]  c_reg   = cmd[20:16];
  wire [15:0] c_data  = cmd[15:0];

  // RULE5: shift on falling edge, MSB first
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 32'h0000_0000;
    end else if (clk_en && !link.sync_n) begin
      // RULE4: MSB first shift
      shift_reg <= {shift_reg[30:0], link.sdin};
    end
  end

  // Bit counter, restarted by the first bit of each new frame
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg    <= 6'h00;
      seen_tog_reg <= 1'b0;
    end else if (clk_en && !link.sync_n) begin
      seen_tog_reg <= frame_tog_reg;
      if (seen_tog_reg != frame_tog_reg) begin
        count_reg <= 6'h01;
      end else if (count_reg != 6'h3F) begin
        count_reg <= count_reg + 6'h01;
      end
    end
  end

  // RULE19: act when select rises
  always_ff @(posedge link.sync_n or negedge rst_n) begin
    if (!rst_n) begin
      // RULE3: checksum on by default
      crc_en_reg   <= 1'b1;
      // RULE11: channel disabled
      dac_cfg_reg  <= dscp_pkg::CFG_RESET;
      reg_cfg1_reg <= dscp_pkg::CFG_RESET;
      // RULE12: pull-down switch open
      reg_cfg2_reg <= dscp_pkg::CFG_RESET;
      // RULE2: code taken as straight binary
      dac_code     <= 16'h0000;
      sw_reset_reg <= 1'b0;
      cal_reg      <= 1'b0;
      crc_err_reg  <= 1'b0;
      frame_tog_reg <= 1'b0;
    end else if (clk_en) begin
      frame_tog_reg <= ~frame_tog_reg;
      crc_err_reg <= len_ok && crc_en_reg && !crc_ok;
      cal_reg     <= good && c_reg == dscp_pkg::REG_GEN_CFG2 && c_data == dscp_pkg::CAL_REFRESH;
      if (good) begin
        case (c_reg)
          dscp_pkg::REG_DATA:     dac_code <= c_data;
          dscp_pkg::REG_DAC_CFG:  dac_cfg_reg <= c_data;
          dscp_pkg::REG_REG_CFG1: reg_cfg1_reg <= c_data;
          dscp_pkg::REG_REG_CFG2: reg_cfg2_reg <= c_data;
          dscp_pkg::REG_GEN_CFG1: crc_en_reg <= c_data[dscp_pkg::CRC_EN_BIT];
          // RULE15: software reset command
          dscp_pkg::REG_SW_RESET: sw_reset_reg <= c_data == dscp_pkg::SW_RESET_KEY;
          default: ;
        endcase
      end
    end
  end

  assign link.sdo = 1'b0;
  // RULE15: reset pin, supply or command
  assign in_reset        = ~rst_n;
  assign out_range       = dac_cfg_reg[dscp_pkg::RANGE_HI:dscp_pkg::RANGE_LO];
  // RULE10: overrange for voltage only
  assign overrange_en    = dac_cfg_reg[dscp_pkg::OVR_BIT] & dac_cfg_reg[dscp_pkg::VMODE_BIT];
  // RULE9: one output stage at a time
  assign voltage_en      = dac_cfg_reg[dscp_pkg::OUT_EN_BIT] & dac_cfg_reg[dscp_pkg::VMODE_BIT];
  assign current_en      = dac_cfg_reg[dscp_pkg::OUT_EN_BIT] & ~dac_cfg_reg[dscp_pkg::VMODE_BIT];
  assign pulldown_closed = reg_cfg2_reg[dscp_pkg::PULLDN_BIT];
  assign ppc_mode        = reg_cfg1_reg[dscp_pkg::PPC_BIT];
  // RULE18: level from bits 4:0
  assign supply_level    = reg_cfg1_reg[dscp_pkg::LEVEL_HI:dscp_pkg::LEVEL_LO];
  assign cal_refresh     = cal_reg;
  assign crc_error       = crc_err_reg;
endmodule

/* File: verification/dscp_link_props.sv */
// Wire-level checks on the serial link between host and device
module dscp_link_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link wires
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo
);
  localparam int RST_CYC = 10000;
  localparam int CAL_CYC = 50000;
  logic [16:0] rst_cnt, cal_cnt, low_cnt;
  logic [5:0]  nbits;
  logic [31:0] word;
  logic        sclk_q, sync_q;
  wire         fall_seen = sclk_q & ~sclk & ~sync_n;
  wire         cal_hit = sync_n & ~sync_q & (nbits == dscp_pkg::FRAME_CNT)
                 & (word[28:24] == dscp_pkg::REG_GEN_CFG2)
                 & (word[23:8] == dscp_pkg::CAL_REFRESH);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
      sync_q <= 1'b1;
      rst_cnt <= 17'h0;
      cal_cnt <= 17'h1FFFF;
      low_cnt <= 17'h0;
      nbits <= 6'h0;
      word <= 32'h0;
    end else begin
      sclk_q <= sclk;
      sync_q <= sync_n;
      rst_cnt <= rst_cnt + {16'h0, ~&rst_cnt};
      cal_cnt <= cal_hit ? 17'h0 : cal_cnt + {16'h0, ~&cal_cnt};
      low_cnt <= sync_n ? 17'h0 : low_cnt + 17'h1;
      nbits <= sync_n ? 6'h0 : nbits + {5'h0, fall_seen};
      if (fall_seen) word <= {word[30:0], sdin};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bit;
    !sclk ##1 sclk;
  endsequence
  sequence s_open;
    $fell(sync_n) ##0 sclk;
  endsequence
  a_sclk_idle: assert property (sync_n |-> sclk)
    else $error("serial clock not idle high");
  a_sclk_rate: assert property ($fell(sclk) |-> s_bit)
    else $error("serial clock low phase wrong");
  a_sdin_stable: assert property (!sclk |-> $stable(sdin))
    else $error("data moved around falling edge");
  a_frame_open: assert property (s_open |=> !sync_n)
    else $error("frame opened badly");
  a_frame_bits: assert property ($rose(sync_n) |-> sclk &&
    (nbits == dscp_pkg::FRAME_CNT || nbits == dscp_pkg::SHORT_CNT))
    else $error("frame length wrong");
  a_frame_bound: assert property (!sync_n |-> low_cnt < 17'd100)
    else $error("frame too long");
  a_reset_quiet: assert property ($fell(sync_n) |-> rst_cnt >= RST_CYC)
    else $error("frame too soon after reset");
  a_cal_quiet: assert property ($fell(sync_n) |-> cal_cnt >= CAL_CYC)
    else $error("frame too soon after refresh");
endmodule

/* File: verification/tb_dac_serial_control_port.sv */
// Testbench joining host and device ends over the serial link
module tb_dac_serial_control_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        dev_reset_seen, reset_pin_n, supply_ok, in_reset, cal_refresh;
  logic        current_en, voltage_en, overrange_en, pulldown_closed, ppc_mode, crc_error;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [15:0] dac_code;
  logic [3:0]  out_range;
  logic [4:0]  supply_level;
  int          n_fail, tests_run;
  localparam logic [2:0] C_CRC = 3'b011, C_RAW = 3'b001, C_SHORT = 3'b101;

  dscp_link_if link_if ();
  dscp_device dscp_device_inst (.link(link_if), .reset_pin_n, .supply_ok,
    .dev_addr_strap_0(1'b0), .dev_addr_strap_1(1'b1), .clk_en(1'b1), .in_reset,
    .dac_code, .current_en, .voltage_en, .overrange_en, .out_range,
    .pulldown_closed, .ppc_mode, .supply_level, .cal_refresh, .crc_error);
  dscp_host dscp_host_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dev_reset_seen,
    .link(link_if));
  dscp_link_props dscp_link_props_inst (.pclk, .presetn, .sclk(link_if.sclk),
    .sync_n(link_if.sync_n), .sdin(link_if.sdin), .sdo(link_if.sdo));

  always #5 pclk = ~pclk;

  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bad(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) bad(m);
  endtask
  task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad("no ready");
      wrap_up;
    end
  endtask
  task idle(input int b);
    int n;
    n = 0;
    do begin
      xfer(dscp_pkg::A_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      bad("status stuck");
      wrap_up;
    end
  endtask
  task send(input logic [31:0] f, input logic [2:0] c);
    idle(dscp_pkg::HOLD_BIT);
    xfer(dscp_pkg::A_WORD, 1'b1, f);
    xfer(dscp_pkg::A_CTRL, 1'b1, {29'h0, c});
    idle(dscp_pkg::BUSY_BIT);
    repeat (4) @(posedge pclk);
  endtask
  task hold_on;
    xfer(dscp_pkg::A_STATUS, 1'b0, 32'h0);
    chk(rd[dscp_pkg::HOLD_BIT], 1, "no hold");
  endtask
  task seen;
    @(posedge pclk);
    dev_reset_seen <= 1'b1;
    @(posedge pclk);
    dev_reset_seen <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [4:0] r, input logic [15:0] d);
    return {1'b0, 2'b10, r, d, 8'h00};
  endfunction
  function automatic logic [7:0] crc8(input logic [23:0] x);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, dev_reset_seen} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_pin_n = 0;
    supply_ok = 1;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reset_pin_n <= 1'b1;
    chk({current_en, voltage_en, pulldown_closed}, 0, "outputs on");
    hold_on;
    xfer(8'h0C, 1'b0, 32'h0);
    chk(er, 1, "unmapped accepted");
    $display("test reset done");
    send(mk(dscp_pkg::REG_DATA, 16'hA5C3), C_CRC);
    chk(dac_code, 16'hA5C3, "code");
    w = mk(dscp_pkg::REG_DATA, 16'h1234);
    send({w[31:8], ~crc8(w[31:8])}, C_RAW);
    chk({crc_error, dac_code}, {1'b1, 16'hA5C3}, "bad checksum");
    w = mk(dscp_pkg::REG_DATA, 16'h5A0F);
    send({w[31:8], crc8(w[31:8])}, C_RAW);
    chk({crc_error, dac_code}, {1'b0, 16'h5A0F}, "good checksum");
    send(mk(dscp_pkg::REG_DATA, 16'h0F0F) ^ 32'h6000_0000, C_CRC);
    chk(dac_code, 16'h5A0F, "address");
    $display("test frames done");
    send(mk(dscp_pkg::REG_DAC_CFG, 16'h00D9), C_CRC);
    chk({voltage_en, current_en, overrange_en, out_range}, 7'h59, "vmode");
    send(mk(dscp_pkg::REG_DAC_CFG, 16'h0045), C_CRC);
    chk({voltage_en, current_en, overrange_en, out_range}, 7'h25, "imode");
    send(mk(dscp_pkg::REG_REG_CFG1, 16'h0033), C_CRC);
    chk({ppc_mode, supply_level}, 6'h33, "level");
    send(mk(dscp_pkg::REG_REG_CFG2, 16'h0001), C_CRC);
    chk(pulldown_closed, 1, "pulldown");
    $display("test config done");
    send(mk(dscp_pkg::REG_GEN_CFG1, 16'h0000), C_CRC);
    send(mk(dscp_pkg::REG_DATA, 16'hC3A5), C_SHORT);
    chk(dac_code, 16'hC3A5, "short");
    send(mk(dscp_pkg::REG_DATA, 16'h0F0F) | 32'h5A, C_RAW);
    chk(dac_code, 16'h0F0F, "long");
    $display("test no checksum done");
    send(mk(dscp_pkg::REG_SW_RESET, dscp_pkg::SW_RESET_KEY), C_CRC);
    seen;
    chk({current_en, voltage_en, pulldown_closed, ppc_mode, supply_level}, 0, "sw");
    reset_pin_n <= 1'b0;
    @(posedge pclk);
    reset_pin_n <= 1'b1;
    supply_ok <= 1'b0;
    chk(in_reset, 1, "pin");
    @(posedge pclk);
    supply_ok <= 1'b1;
    chk(in_reset, 1, "supply");
    @(posedge pclk);
    chk(in_reset, 0, "stuck");
    seen;
    hold_on;
    send(mk(dscp_pkg::REG_DATA, 16'h1234), C_RAW);
    chk(crc_error, 1, "checksum off");
    $display("test resets done");
    send(mk(dscp_pkg::REG_GEN_CFG2, dscp_pkg::CAL_REFRESH), C_CRC);
    chk(cal_refresh, 1, "refresh");
    hold_on;
    send(mk(dscp_pkg::REG_DATA, 16'h8001), C_CRC);
    chk({cal_refresh, dac_code}, {1'b0, 16'h8001}, "after refresh");
    $display("test calibration done");
    wrap_up;
  end
endmodule
